// file: common/mdh_pkg.sv
// constants and types shared by the motion detect host interface
`default_nettype none
package mdh_pkg;
  // ****************************************
  // clock and serial timing
  // ****************************************
  localparam int CLK_HZ    = 20_000_000;
  localparam int BAUD_BPS  = 9600;
  localparam logic [11:0] BIT_CNT  = 12'(CLK_HZ / BAUD_BPS);
  localparam logic [11:0] HALF_CNT = 12'(CLK_HZ / BAUD_BPS / 2);
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h9;
  // ****************************************
  // seconds based timing
  // ****************************************
  localparam int STAB_SEC = 15;
  localparam logic [12:0] HOLD_MIN_S = 13'h0001;
  localparam logic [12:0] HOLD_MAX_S = 13'(128 * 60);
  localparam logic [12:0] HW_HOLD_MIN_S = 13'h0002;
  localparam logic [12:0] HW_HOLD_MAX_S = 13'(15 * 60);
  localparam logic [12:0] HW_HOLD_1 = 13'h001e;
  localparam logic [12:0] HW_HOLD_2 = 13'h0078;
  localparam logic [3:0]  BOOST_SEC = 4'h8;
  localparam logic [3:0]  STAB_CNT  = 4'(STAB_SEC);
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SENS = 8'h04;
  localparam logic [7:0] ADR_HOLD = 8'h08;
  localparam logic [7:0] ADR_LTHR = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam int CTRL_BOOST = 0;
  localparam int CTRL_LFREJ = 1;
  localparam int CTRL_DIR   = 2;
  localparam int STAT_SEEN  = 5;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [3:0]  SENS_RST = 4'h8;
  localparam logic [12:0] HOLD_RST = 13'h0005;
  localparam logic [3:0]  LTHR_RST = 4'h8;
  localparam logic [3:0]  HW_LTHR  = 4'h8;
  localparam logic [3:0]  STRENGTH_MAX = 4'hf;
  // ****************************************
  // serial command byte
  // ****************************************
  localparam int CMD_WR = 7;
  localparam logic [2:0] SIDX_CTRL = 3'h0;
  localparam logic [2:0] SIDX_SENS = 3'h1;
  localparam logic [2:0] SIDX_HOLDL = 3'h2;
  localparam logic [2:0] SIDX_HOLDH = 3'h3;
  localparam logic [2:0] SIDX_LTHR = 3'h4;
  localparam logic [2:0] SIDX_STAT = 3'h5;
  localparam logic [9:0] PIN_SYNC_RST = 10'h001;
  typedef enum logic [1:0] {CMD_IDLE = 2'b01, CMD_DATA = 2'b10} mdh_cmd_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} mdh_tx_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } mdh_rx_t;
endpackage
`default_nettype wire

// file: hw/mdh_uart_rx.sv
// serial receiver, 8N1, line synchronised inside
`timescale 1ns/1ns
`default_nettype none
module mdh_uart_rx (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       rxd,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data
);
  import mdh_pkg::*;
  logic       rxd_meta;
  logic       rxd_s;
  mdh_rx_t    state;
  logic [11:0] cnt;
  logic [3:0] bitn;
  logic [7:0] shift;
  wire        bit_end  = (cnt == BIT_CNT - 12'h001);
  wire        half_end = (cnt == HALF_CNT - 12'h001);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_s    <= rxd_meta;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state    <= RX_IDLE;
      cnt      <= 12'h000;
      bitn     <= 4'h0;
      shift    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      cnt      <= cnt + 12'h001;
      case (state)
        RX_IDLE: begin
          cnt <= 12'h000;
          if (!rxd_s) state <= RX_START;
        end
        RX_START: if (half_end) begin
          cnt   <= 12'h000;
          bitn  <= 4'h0;
          state <= rxd_s ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (bit_end) begin
          cnt   <= 12'h000;
          shift <= {rxd_s, shift[7:1]};
          bitn  <= bitn + 4'h1;
          if (bitn == LAST_DATA_BIT) state <= RX_STOP;
        end
        RX_STOP: if (bit_end) begin
          state <= RX_IDLE;
          if (rxd_s) begin
            rx_valid <= 1'b1;
            rx_data  <= shift;
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end
endmodule // mdh_uart_rx
`default_nettype wire

// file: hw/mdh_uart_tx.sv
// serial transmitter, 8N1
`timescale 1ns/1ns
`default_nettype none
module mdh_uart_tx (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  output wire logic       tx_ready,
  output var  logic       txd
);
  import mdh_pkg::*;
  mdh_tx_t     state;
  logic [11:0] cnt;
  logic [3:0]  bitn;
  logic [8:0]  shift;
  wire         bit_end = (cnt == BIT_CNT - 12'h001);
  assign tx_ready = (state == TX_IDLE);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= TX_IDLE;
      cnt   <= 12'h000;
      bitn  <= 4'h0;
      shift <= 9'h1ff;
      txd   <= 1'b1;
    end else begin
      case (state)
        TX_IDLE: if (tx_start) begin
          shift <= {1'b1, tx_data};
          txd   <= 1'b0;
          cnt   <= 12'h000;
          bitn  <= 4'h0;
          state <= TX_RUN;
        end
        TX_RUN: begin
          cnt <= bit_end ? 12'h000 : cnt + 12'h001;
          if (bit_end) begin
            bitn <= bitn + 4'h1;
            if (bitn == LAST_TX_BIT) begin
              state <= TX_IDLE;
            end else begin
              txd   <= shift[0];
              shift <= {1'b1, shift[8:1]};
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  a_tx_start_low: assert property (@(posedge clock) disable iff (!rstn)
    tx_ready && tx_start |=> !txd [*8])
    else $error("start bit not driven low");
endmodule // mdh_uart_tx
`default_nettype wire

// file: hw/mdh_top.sv
// motion output, pin and serial configuration, wishbone registers
`timescale 1ns/1ns
`default_nettype none
module mdh_top #(
  parameter int SEC_CYCLES = mdh_pkg::CLK_HZ
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        serial_mode_pin,
  input  wire logic        sleep_request_n,
  input  wire logic [1:0]  sensitivity_level_pin,
  input  wire logic [1:0]  hold_time_pin,
  input  wire logic [3:0]  light_gate_input,
  input  wire logic        sensor_stable,
  input  wire logic        sample_valid,
  input  wire logic [3:0]  motion_strength,
  input  wire logic        rxd,
  output wire logic        txd,
  output var  logic        motion_flag_n,
  output var  logic        sleep_active,
  output var  logic        boosted_sensitivity_mode,
  output var  logic        cfg_lf_reject,
  output var  logic        cfg_directional
);
  import mdh_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [9:0] pin_meta;
  logic [9:0] pin_s;
  wire  [9:0] pin_raw = {light_gate_input, hold_time_pin, sensitivity_level_pin,
                         serial_mode_pin, sleep_request_n};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= PIN_SYNC_RST;
      pin_s    <= PIN_SYNC_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end
  wire       sleep_s  = !pin_s[0];
  wire       serial_s = pin_s[1];
  wire [1:0] sens_pin = pin_s[3:2];
  wire [1:0] hold_pin = pin_s[5:4];
  wire [3:0] light_s  = pin_s[9:6];

  // ****************************************
  // configuration registers
  // ****************************************
  logic [2:0]  ctrl;
  logic [3:0]  sens_reg;
  logic [12:0] hold_reg;
  logic [3:0]  lthr_reg;
  logic        motion_seen;
  wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr   = wb_req && wb_we_i;
  wire wr_ctrl = wb_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0];
  wire wr_sens = wb_wr && wb_adr_i == ADR_SENS && wb_sel_i[0];
  wire wr_hl   = wb_wr && wb_adr_i == ADR_HOLD && wb_sel_i[0];
  wire wr_hh   = wb_wr && wb_adr_i == ADR_HOLD && wb_sel_i[1];
  wire wr_lthr = wb_wr && wb_adr_i == ADR_LTHR && wb_sel_i[0];
  wire wr_stat = wb_wr && wb_adr_i == ADR_STAT && wb_sel_i[0];

  // ****************************************
  // serial command parser
  // ****************************************
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_ready;
  logic       tx_start;
  logic [7:0] tx_data;
  mdh_cmd_t   cmd_state;
  logic [2:0] cmd_idx;
  wire        cmd_byte = rx_valid && cmd_state == CMD_IDLE;
  wire        s_wr     = rx_valid && cmd_state == CMD_DATA;
  wire        s_rd     = cmd_byte && !rx_data[CMD_WR] && serial_s;
  wire        s_ctrl   = s_wr && cmd_idx == SIDX_CTRL;
  wire        s_sens   = s_wr && cmd_idx == SIDX_SENS;
  wire        s_hl     = s_wr && cmd_idx == SIDX_HOLDL;
  wire        s_hh     = s_wr && cmd_idx == SIDX_HOLDH;
  wire        s_lthr   = s_wr && cmd_idx == SIDX_LTHR;

  mdh_uart_rx u_rx (
    .clock    (clock),
    .rstn     (rstn),
    .rxd      (rxd),
    .rx_valid (rx_valid),
    .rx_data  (rx_data)
  );
  mdh_uart_tx u_tx (
    .clock    (clock),
    .rstn     (rstn),
    .tx_start (tx_start),
    .tx_data  (tx_data),
    .tx_ready (tx_ready),
    .txd      (txd)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_state <= CMD_IDLE;
      cmd_idx   <= 3'h0;
    end else begin
      case (cmd_state)
        CMD_IDLE: if (cmd_byte && rx_data[CMD_WR] && serial_s) begin
          cmd_idx   <= rx_data[2:0];
          cmd_state <= CMD_DATA;
        end else if (cmd_byte) begin
          cmd_idx   <= rx_data[2:0];
        end
        CMD_DATA: if (rx_valid) cmd_state <= CMD_IDLE;
        default:  cmd_state <= CMD_IDLE;
      endcase
    end
  end

  // bus write wins over a serial write in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl     <= CTRL_RST;
      sens_reg <= SENS_RST;
      hold_reg <= HOLD_RST;
      lthr_reg <= LTHR_RST;
    end else begin
      if (wr_ctrl) ctrl <= wb_dat_i[2:0];
      else if (s_ctrl) ctrl <= rx_data[2:0];
      if (wr_sens) sens_reg <= wb_dat_i[3:0];
      else if (s_sens) sens_reg <= rx_data[3:0];
      if (wr_hl) hold_reg[7:0] <= wb_dat_i[7:0];
      else if (s_hl) hold_reg[7:0] <= rx_data;
      if (wr_hh) hold_reg[12:8] <= wb_dat_i[12:8];
      else if (s_hh) hold_reg[12:8] <= rx_data[4:0];
      if (wr_lthr) lthr_reg <= wb_dat_i[3:0];
      else if (s_lthr) lthr_reg <= rx_data[3:0];
    end
  end

  // ****************************************
  // effective settings per mode
  // ****************************************
  logic [12:0] hw_hold;
  always_comb begin
    case (hold_pin)
      2'h0:    hw_hold = HW_HOLD_MIN_S;
      2'h1:    hw_hold = HW_HOLD_1;
      2'h2:    hw_hold = HW_HOLD_2;
      default: hw_hold = HW_HOLD_MAX_S;
    endcase
  end
  wire [12:0] ser_hold = (hold_reg < HOLD_MIN_S) ? HOLD_MIN_S :
                         (hold_reg > HOLD_MAX_S) ? HOLD_MAX_S : hold_reg;
  wire [12:0] hold_sec = serial_s ? ser_hold : hw_hold;
  wire [3:0]  sens_eff = serial_s ? sens_reg : {sens_pin, sens_pin};
  wire [3:0]  lthr_eff = serial_s ? lthr_reg : HW_LTHR;
  wire        boost_en = serial_s && ctrl[CTRL_BOOST];

  // ****************************************
  // seconds tick and stabilization
  // ****************************************
  logic [31:0] sec_div;
  logic [3:0]  stab_sec;
  logic        stable_seen;
  wire         sec_tick = (sec_div == 32'(SEC_CYCLES - 1));
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sec_div     <= 32'h0000_0000;
      stab_sec    <= 4'h0;
      stable_seen <= 1'b0;
    end else begin
      sec_div <= sec_tick ? 32'h0000_0000 : sec_div + 32'h0000_0001;
      if (sec_tick && stab_sec != STAB_CNT) stab_sec <= stab_sec + 4'h1;
      if (stab_sec == STAB_CNT && sensor_stable) stable_seen <= 1'b1;
    end
  end

  // ****************************************
  // detection, gating and hold
  // ****************************************
  logic [3:0]  boost_left;
  logic [12:0] hold_left;
  logic [12:0] next_hold;
  logic [31:0] hold_div;
  wire  [3:0]  base_thr   = STRENGTH_MAX - sens_eff;
  wire         boost_on   = boost_en && boost_left != 4'h0;
  wire  [3:0]  thr        = (boost_on && base_thr > 4'h1) ? base_thr - 4'h1 : base_thr;
  wire         light_over = light_s > lthr_eff;
  wire         armed      = stable_seen && !sleep_s && !light_over;
  wire         hit        = sample_valid && motion_strength >= thr;
  wire         hold_tick  = (hold_div == 32'(SEC_CYCLES - 1));
  always_comb begin
    next_hold = hold_left;
    if (hit && armed) next_hold = hold_sec;
    else if (hold_tick && hold_left != 13'h0000) next_hold = hold_left - 13'h0001;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_left  <= 13'h0000;
      hold_div   <= 32'h0000_0000;
      boost_left <= 4'h0;
    end else begin
      hold_left <= next_hold;
      if ((hit && armed) || hold_tick) hold_div <= 32'h0000_0000;
      else hold_div <= hold_div + 32'h0000_0001;
      if (hit && armed && boost_en) boost_left <= BOOST_SEC;
      else if (sec_tick && boost_left != 4'h0) boost_left <= boost_left - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      motion_flag_n            <= 1'b1;
      sleep_active             <= 1'b0;
      boosted_sensitivity_mode <= 1'b0;
      cfg_lf_reject            <= 1'b0;
      cfg_directional          <= 1'b0;
      motion_seen              <= 1'b0;
    end else begin
      motion_flag_n <= !(next_hold != 13'h0000 && !sleep_s && !light_over);
      sleep_active  <= sleep_s;
      boosted_sensitivity_mode <= boost_on;
      cfg_lf_reject   <= serial_s && ctrl[CTRL_LFREJ];
      cfg_directional <= serial_s && ctrl[CTRL_DIR];
      if (hit && armed) motion_seen <= 1'b1;
      else if (wr_stat && wb_dat_i[STAT_SEEN]) motion_seen <= 1'b0;
    end
  end

  // ****************************************
  // status, serial reply, bus read
  // ****************************************
  wire [7:0] status = {2'h0, motion_seen, !motion_flag_n, light_over,
                       stable_seen, sleep_s, serial_s};
  logic [7:0] s_rd_val;
  always_comb begin
    case (rx_data[2:0])
      SIDX_CTRL:  s_rd_val = {5'h00, ctrl};
      SIDX_SENS:  s_rd_val = {4'h0, sens_reg};
      SIDX_HOLDL: s_rd_val = hold_reg[7:0];
      SIDX_HOLDH: s_rd_val = {3'h0, hold_reg[12:8]};
      SIDX_LTHR:  s_rd_val = {4'h0, lthr_reg};
      SIDX_STAT:  s_rd_val = status;
      default:    s_rd_val = 8'h00;
    endcase
  end
  assign tx_start = s_rd && tx_ready;
  assign tx_data  = s_rd_val;

  logic [31:0] rd_val;
  always_comb begin
    case (wb_adr_i)
      ADR_CTRL: rd_val = {29'h0, ctrl};
      ADR_SENS: rd_val = {28'h0, sens_reg};
      ADR_HOLD: rd_val = {19'h0, hold_reg};
      ADR_LTHR: rd_val = {28'h0, lthr_reg};
      ADR_STAT: rd_val = {24'h0, status};
      default:  rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? rd_val : 32'h0000_0000;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_hit_armed;
    hit && armed;
  endsequence
  sequence s_flag_on;
    !motion_flag_n;
  endsequence
  a_ack_one_cycle: assert property (@(posedge clock) disable iff (!rstn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle answer");
  a_sleep_quiet: assert property (@(posedge clock) disable iff (!rstn)
    sleep_s |=> motion_flag_n && sleep_active)
    else $error("motion flag active during sleep");
  a_hit_flag: assert property (@(posedge clock) disable iff (!rstn)
    s_hit_armed |=> s_flag_on)
    else $error("hit did not activate motion flag");
  a_light_gate: assert property (@(posedge clock) disable iff (!rstn)
    light_over |=> motion_flag_n)
    else $error("motion flag active above light threshold");
  a_stable_wait: assert property (@(posedge clock) disable iff (!rstn)
    !stable_seen |=> motion_flag_n)
    else $error("motion flag before sensor stable");
  a_stab_min: assert property (@(posedge clock) disable iff (!rstn)
    $rose(stable_seen) |-> $past(stab_sec) == STAB_CNT)
    else $error("stabilization shorter than minimum");
  a_hold_range: assert property (@(posedge clock) disable iff (!rstn)
    serial_s |-> hold_sec >= HOLD_MIN_S && hold_sec <= HOLD_MAX_S)
    else $error("serial hold out of range");
  a_hw_hold: assert property (@(posedge clock) disable iff (!rstn)
    !serial_s |-> hold_sec >= HW_HOLD_MIN_S && hold_sec <= HW_HOLD_MAX_S)
    else $error("hardware hold out of range");
  a_boost_thr: assert property (@(posedge clock) disable iff (!rstn)
    s_hit_armed ##0 boost_en ##1 boost_en && base_thr > 4'h1 |-> thr == base_thr - 4'h1)
    else $error("boost did not lower threshold");
  a_serial_read: assert property (@(posedge clock) disable iff (!rstn)
    s_rd && tx_ready |=> !tx_ready)
    else $error("serial read not answered");
endmodule // mdh_top
`default_nettype wire

// file: dv/mdh_host_model.sv
// host partner model driving and reading the serial lines
`timescale 1ns/1ns
`default_nettype none
module mdh_host_model (
  input  wire logic       clock,
  input  wire logic       send,
  input  wire logic [7:0] send_data,
  input  wire logic       line_in,
  output var  logic       line_out,
  output var  logic       busy,
  output var  logic [7:0] got_data,
  output var  logic       got_ok,
  output var  int         got_cnt
);
  import mdh_pkg::*;
  localparam int BT = int'(BIT_CNT);
  logic [7:0] sh;
  logic [7:0] d;
  initial begin
    line_out = 1'h1;
    busy = 1'h0;
    got_data = 8'h00;
    got_ok = 1'h0;
    got_cnt = 0;
  end
  // ****************************************
  // transmit one frame, line idles high
  // ****************************************
  always @(posedge clock) begin
    if (send === 1'h1) begin
      sh = send_data;
      busy <= 1'h1;
      line_out <= 1'h0;
      for (int i = 0; i < 10; i++) begin
        repeat (BT) @(posedge clock);
        line_out <= (i < 8) ? sh[i] : 1'h1;
      end
      busy <= 1'h0;
    end
  end
  // ****************************************
  // receive, sampled mid bit
  // ****************************************
  always @(posedge clock) begin
    if (line_in === 1'h0) begin
      repeat (BT / 2) @(posedge clock);
      for (int i = 0; i < 9; i++) begin
        repeat (BT) @(posedge clock);
        if (i < 8) d[i] = line_in;
      end
      got_ok <= (line_in === 1'h1);
      got_data <= d;
      got_cnt <= got_cnt + 1;
    end
  end
endmodule // mdh_host_model
`default_nettype wire

// file: dv/tb.sv
// self-checking bench: bus, pins, motion output and serial host
`timescale 1ns/1ns
`default_nettype none
module tb;
  import mdh_pkg::*;
  localparam int SEC = 10;
  localparam int HWS [4] = '{int'(HW_HOLD_MIN_S), int'(HW_HOLD_1), int'(HW_HOLD_2),
                             int'(HW_HOLD_MAX_S)};
  localparam logic [7:0]  RA [5] = '{ADR_CTRL, ADR_SENS, ADR_HOLD, ADR_LTHR, 8'h20};
  localparam logic [31:0] RV [5] = '{32'(CTRL_RST), 32'(SENS_RST), 32'(HOLD_RST),
                                     32'(LTHR_RST), 32'h0000_0000};
  logic        clock = 1'h0;
  logic        rstn, cyc, stb, we, smode, slp_n, stable, sv, ack, txd, rxd;
  logic        flag_n, sleeping, boost, lfr, dirn, hsend, hbusy, got_ok;
  logic [1:0]  spin, hpin;
  logic [3:0]  light, str, sens, thr;
  logic [7:0]  adr, hdata, got;
  logic [31:0] wdat, dato, rdat;
  int          n_fail = 0, check_count = 0, cycles = 0, seed, got_cnt, n0;
  always #25 clock = ~clock;
  mdh_top #(.SEC_CYCLES(SEC)) dut_u (
    .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .serial_mode_pin(smode), .sleep_request_n(slp_n), .sensitivity_level_pin(spin),
    .hold_time_pin(hpin), .light_gate_input(light), .sensor_stable(stable),
    .sample_valid(sv), .motion_strength(str), .rxd(rxd), .txd(txd),
    .motion_flag_n(flag_n), .sleep_active(sleeping), .boosted_sensitivity_mode(boost),
    .cfg_lf_reject(lfr), .cfg_directional(dirn));
  mdh_host_model host_u (
    .clock(clock), .send(hsend), .send_data(hdata), .line_in(txd), .line_out(rxd),
    .busy(hbusy), .got_data(got), .got_ok(got_ok), .got_cnt(got_cnt));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clock);
    while (ack !== 1'h1);
    chk(ack, 1'h1);
    rdat = dato;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  // hit, then flag low for n cycles, or none when n is 0
  task automatic hit_chk(input logic [3:0] s, input int n);
    @(posedge clock);
    sv <= 1'h1;
    str <= s;
    @(posedge clock);
    sv <= 1'h0;
    @(posedge clock);
    #1;
    chk(flag_n, n == 0);
    if (n > 0) begin
      repeat (n - 2) @(posedge clock);
      #1;
      chk(flag_n, 1'h0);
      repeat (3) @(posedge clock);
      #1;
      chk(flag_n, 1'h1);
    end
    @(posedge clock);
  endtask
  task automatic ser_send(input logic [7:0] b);
    @(posedge clock);
    hsend <= 1'h1;
    hdata <= b;
    @(posedge clock);
    hsend <= 1'h0;
    @(posedge clock);
    while (hbusy === 1'h1) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 99000) begin
      n_fail++;
      $display("MISMATCH t=%0t run took too long", $time);
      stop_test;
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    seed = 32'h0000_77a2;
    {rstn, cyc, stb, we, stable, sv, hsend} = '0;
    {smode, slp_n} = 2'h3;
    {spin, hpin, light, str, adr, hdata, wdat} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'h1;
    wb(1'h1, 8'h20, 32'hffff_ffff);
    for (int i = 0; i < 5; i++) rd(RA[i], RV[i]);
    $display("test reset_values done");
    repeat (17 * SEC) @(posedge clock);
    hit_chk(4'hf, 0);
    rd(ADR_STAT, 32'h0000_0001);
    stable <= 1'h1;
    repeat (SEC + 2) @(posedge clock);
    hit_chk(4'hf, 5 * SEC);
    rstn <= 1'h0;
    @(posedge clock);
    rstn <= 1'h1;
    repeat (10 * SEC) @(posedge clock);
    hit_chk(4'hf, 0);
    repeat (7 * SEC) @(posedge clock);
    hit_chk(4'hf, 5 * SEC);
    $display("test stabilization done");
    wb(1'h1, ADR_HOLD, 32'h0000_0002);
    hit_chk(4'hf, 2 * SEC);
    wb(1'h1, ADR_HOLD, 32'h0000_0000);
    hit_chk(4'hf, int'(HOLD_MIN_S) * SEC);
    thr = 4'({$random(seed)} % 15);
    wb(1'h1, ADR_LTHR, 32'(thr));
    light <= thr + 4'h1;
    repeat (4) @(posedge clock);
    hit_chk(4'hf, 0);
    light <= thr;
    repeat (4) @(posedge clock);
    hit_chk(4'hf, SEC);
    light <= 4'h0;
    slp_n <= 1'h0;
    repeat (4) @(posedge clock);
    chk(sleeping, 1'h1);
    hit_chk(4'hf, 0);
    slp_n <= 1'h1;
    repeat (4) @(posedge clock);
    chk(sleeping, 1'h0);
    $display("test serial_motion done");
    sens = 4'(2 + {$random(seed)} % 12);
    wb(1'h1, ADR_SENS, 32'(sens));
    wb(1'h1, ADR_CTRL, 32'h0000_0001);
    hit_chk(4'hf - sens, SEC);
    chk(boost, 1'h1);
    hit_chk(4'he - sens, SEC);
    repeat (9 * SEC) @(posedge clock);
    chk(boost, 1'h0);
    hit_chk(4'he - sens, 0);
    rd(ADR_STAT, 32'h0000_0025);
    wb(1'h1, ADR_STAT, 32'h0000_0020);
    rd(ADR_STAT, 32'h0000_0005);
    wb(1'h1, ADR_CTRL, 32'h0000_0000);
    $display("test boost done");
    smode <= 1'h0;
    spin <= 2'h1;
    for (int h = 0; h < 4; h++) begin
      hpin <= 2'(h);
      repeat (4) @(posedge clock);
      hit_chk(4'ha, HWS[h] * SEC);
    end
    hit_chk(4'h9, 0);
    light <= HW_LTHR + 4'h1;
    repeat (4) @(posedge clock);
    hit_chk(4'ha, 0);
    light <= 4'h0;
    $display("test hardware_mode done");
    smode <= 1'h1;
    ser_send({1'h1, 4'h0, SIDX_CTRL});
    ser_send(8'h06);
    repeat (4) @(posedge clock);
    chk(lfr, 1'h1);
    chk(dirn, 1'h1);
    n0 = got_cnt;
    ser_send({5'h00, SIDX_SENS});
    while (got_cnt == n0) @(posedge clock);
    chk(got, {4'h0, sens});
    chk(got_ok, 1'h1);
    $display("test serial_link done");
    stop_test;
  end
endmodule // tb
`default_nettype wire
